/* core/pos_edge_delay.sv */
// Active-edge delay: holds back each rising PWM edge by a count of four-clock units
`timescale 1ns/1ps
module pos_edge_delay (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pwm_in,
    input wire logic [6:0] delay_count,
    output logic pwm_out
);
    logic pwm_prev_reg;
    logic waiting_reg;
    logic [1:0] qdiv_reg;
    logic [6:0] remain_reg;
    logic pwm_out_reg;
    wire rise = pwm_in && !pwm_prev_reg;
    // Quarter divider restarts on the edge so every delay is exact to the clock
    wire qtick = waiting_reg && (qdiv_reg == pos_pkg::POS_QCYC_LAST);
    wire expire = qtick && (remain_reg == 7'h01);

    ////////////////////////////////////////////////////////////////////////////
    // Delay counter; a falling edge passes at once and cancels a pending rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_prev_reg <= 1'b0;
            waiting_reg <= 1'b0;
            qdiv_reg <= 2'h0;
            remain_reg <= 7'h00;
            pwm_out_reg <= 1'b0;
        end else begin
            pwm_prev_reg <= pwm_in;
            if (!pwm_in) begin
                waiting_reg <= 1'b0;
                pwm_out_reg <= 1'b0;
            end else if (rise && delay_count == 7'h00) begin
                pwm_out_reg <= 1'b1;
            end else if (rise) begin
                waiting_reg <= 1'b1;
                qdiv_reg <= 2'h0;
                remain_reg <= delay_count;
            end else if (waiting_reg) begin
                qdiv_reg <= qdiv_reg + 2'h1;
                if (qtick) begin
                    remain_reg <= remain_reg - 7'h01;
                end
                if (expire) begin
                    waiting_reg <= 1'b0;
                    pwm_out_reg <= 1'b1;
                end
            end
        end
    end

    assign pwm_out = pwm_out_reg;
endmodule : pos_edge_delay

/* core/pos_pin_steer.sv */
// One output pin of the steering stage: PWM or port, polarity and shutdown forcing
`timescale 1ns/1ps
module pos_pin_steer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic steer_active,
    input wire logic steer_en,
    input wire logic pwm,
    input wire logic invert,
    input wire logic shutdown,
    input wire logic port_data,
    input wire logic dir_input,
    output logic pin_o,
    output logic pin_oe
);
    logic pin_o_reg;
    logic pin_oe_reg;
    wire use_pwm = steer_active && steer_en;
    // Shutdown drives the inactive level of the chosen polarity
    wire pwm_level = shutdown ? invert : (pwm ^ invert);
    wire pin_next = use_pwm ? pwm_level : port_data;

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin; driver follows the port direction, as software must set it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_o_reg <= pin_next;
            pin_oe_reg <= !dir_input;
        end
    end

    assign pin_o = pin_o_reg;
    assign pin_oe = pin_oe_reg;
endmodule : pos_pin_steer

/* core/pos_pkg.sv */
// Package: register map, field layout, reset values and types for the PWM output steering block
package pos_pkg;

    // Register byte offsets
    localparam logic [7:0] POS_OFF_RESTART_DELAY = 8'h00;
    localparam logic [7:0] POS_OFF_STEERING = 8'h04;
    localparam logic [7:0] POS_OFF_STATUS = 8'h08;

    // Restart/delay register layout
    localparam int POS_RD_RESTART_BIT = 7;
    localparam int POS_RD_DELAY_LSB = 0;
    localparam int POS_RD_DELAY_W = 7;
    localparam logic [7:0] POS_RD_RESET = 8'h00;

    // Steering register layout
    localparam int POS_ST_EN_LSB = 0;
    localparam int POS_ST_SYNC_BIT = 4;
    localparam logic [7:0] POS_ST_WMASK = 8'h1f;
    localparam logic [7:0] POS_ST_RESET = 8'h01;

    // Status register layout
    localparam int POS_SS_SHUTDOWN_BIT = 0;
    localparam int POS_SS_ACTIVE_BIT = 1;
    localparam int POS_SS_EFF_LSB = 4;

    // Mode decode values
    localparam logic [1:0] POS_MODE_PWM = 2'h3;
    localparam logic [1:0] POS_CFG_SINGLE = 2'h0;
    // Polarity bits of the channel mode field: bit 1 inverts A/C, bit 0 inverts B/D
    localparam int POS_POL_AC_BIT = 1;
    localparam int POS_POL_BD_BIT = 0;

    // One delay unit is four oscillator (hclk) periods
    localparam logic [1:0] POS_QCYC_LAST = 2'h3;

    localparam int POS_PINS = 4;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } pos_ahb_req_t;

endpackage : pos_pkg

/* core/pos_top.sv */
// Top of the PWM output steering block: AHB-Lite registers, steering, shutdown and delay
`timescale 1ns/1ps
module pos_top (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Rest of the PWM unit, same clock
    input wire logic [3:0] channel_mode_field,
    input wire logic [1:0] output_config_field,
    input wire logic period_start,
    input wire logic pwm_raw,
    input wire logic shutdown_event,
    // Port side of the pins
    input wire logic [3:0] port_data,
    input wire logic [3:0] pin_direction_control,
    // Pins A..D, then shutdown and steering status
    output logic [3:0] pwm_pin_o,
    output logic [3:0] pwm_pin_oe,
    output logic shutdown_status_flag,
    output logic steer_active
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    pos_pkg::pos_ahb_req_t req_reg;
    pos_pkg::pos_ahb_req_t req_next;
    logic [7:0] restart_delay_reg;
    logic [7:0] steering_reg;
    logic [3:0] steer_eff_reg;
    logic [3:0] steer_eff_next;
    logic shutdown_reg;
    logic shutdown_next;
    logic pwm_delayed;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture
    // The slave never stalls, so hreadyout is a constant high and every
    // answer is OKAY. Only whole-word single transfers are expected; the
    // byte offset low bits are ignored so a misaligned word still hits.

    wire addr_phase = hsel && hready && htrans[1];

    always_comb begin
        req_next.valid = addr_phase;
        req_next.write = hwrite;
        req_next.addr = {haddr[7:2], 2'b00};
    end

    // Data-phase selects decoded from the captured address
    wire sel_rd = req_reg.addr == pos_pkg::POS_OFF_RESTART_DELAY;
    wire sel_st = req_reg.addr == pos_pkg::POS_OFF_STEERING;
    wire sel_ss = req_reg.addr == pos_pkg::POS_OFF_STATUS;
    wire wr_phase = req_reg.valid && req_reg.write;
    wire wr_rd = wr_phase && sel_rd;
    wire wr_st = wr_phase && sel_st;
    wire wr_ss = wr_phase && sel_ss;

    // Address phase register; reloaded on every cycle with hready high, held only while hready is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg <= '0;
        end else if (hready) begin
            req_reg <= req_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    // Restart enable and edge delay count, all bits read/write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_delay_reg <= pos_pkg::POS_RD_RESET;
        end else if (wr_rd) begin
            restart_delay_reg <= hwdata[7:0];
        end
    end

    // Steering control; the top three bits are not stored and read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            steering_reg <= pos_pkg::POS_ST_RESET;
        end else if (wr_st) begin
            steering_reg <= hwdata[7:0] & pos_pkg::POS_ST_WMASK;
        end
    end

    wire restart_en = restart_delay_reg[pos_pkg::POS_RD_RESTART_BIT];
    wire [6:0] delay_count = restart_delay_reg[pos_pkg::POS_RD_DELAY_LSB +: pos_pkg::POS_RD_DELAY_W];
    wire steer_sync = steering_reg[pos_pkg::POS_ST_SYNC_BIT];
    wire [3:0] steer_req = steering_reg[pos_pkg::POS_ST_EN_LSB +: pos_pkg::POS_PINS];

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    // Steering only exists in single-output PWM; in any other mode all
    // four pins fall back to port control whatever the enables say.

    assign steer_active = (channel_mode_field[3:2] == pos_pkg::POS_MODE_PWM)
                          && (output_config_field == pos_pkg::POS_CFG_SINGLE);

    wire inv_ac = channel_mode_field[pos_pkg::POS_POL_AC_BIT];
    wire inv_bd = channel_mode_field[pos_pkg::POS_POL_BD_BIT];
    wire [3:0] pin_invert = {inv_bd, inv_ac, inv_bd, inv_ac};

    ////////////////////////////////////////////////////////////////////////////
    // Effective steering
    // Without sync the stored enables take effect the cycle after the write,
    // which may clip a pulse; with sync they wait for the period-start pulse
    // so each pin only ever sees whole periods. A write landing on the same
    // edge as period_start is picked up at the following period start.

    always_comb begin
        steer_eff_next = steer_eff_reg;
        if (!steer_sync) begin
            steer_eff_next = steer_req;
        end else if (period_start) begin
            steer_eff_next = steer_req;
        end
    end

    // Enables actually applied to the pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            steer_eff_reg <= pos_pkg::POS_ST_RESET[3:0];
        end else begin
            steer_eff_reg <= steer_eff_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shutdown status flag
    // Set while the shutdown cause stands; the set wins over any clear.
    // With restart enabled the flag drops by itself once the cause is gone;
    // otherwise software clears it by writing one to its status bit.

    wire sw_clear = wr_ss && hwdata[pos_pkg::POS_SS_SHUTDOWN_BIT];

    always_comb begin
        shutdown_next = shutdown_reg;
        if (shutdown_event) begin
            shutdown_next = 1'b1;
        end else if (restart_en) begin
            shutdown_next = 1'b0;
        end else if (sw_clear) begin
            shutdown_next = 1'b0;
        end
    end

    // Flag flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shutdown_reg <= 1'b0;
        end else begin
            shutdown_reg <= shutdown_next;
        end
    end

    assign shutdown_status_flag = shutdown_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Active-edge delay on the raw PWM before steering

    pos_edge_delay u_delay (
        .hclk(hclk),
        .hresetn(hresetn),
        .pwm_in(pwm_raw),
        .delay_count(delay_count),
        .pwm_out(pwm_delayed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin stages A..D
    // The same delayed PWM feeds every pin so several can carry it at once.

    genvar gi;
    generate
        for (gi = 0; gi < pos_pkg::POS_PINS; gi++) begin : g_pin
            pos_pin_steer u_pin (
                .hclk(hclk),
                .hresetn(hresetn),
                .steer_active(steer_active),
                .steer_en(steer_eff_reg[gi]),
                .pwm(pwm_delayed),
                .invert(pin_invert[gi]),
                .shutdown(shutdown_reg),
                .port_data(port_data[gi]),
                .dir_input(pin_direction_control[gi]),
                .pin_o(pwm_pin_o[gi]),
                .pin_oe(pwm_pin_oe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    // Read data comes straight from the register flops through the decoded
    // select, so a read right after a write already sees the new value.
    // Unmapped offsets read zero and ignore writes.

    wire [7:0] status_word = {steer_eff_reg, 2'b00, steer_active, shutdown_reg};
    wire [7:0] rd_byte = sel_rd ? restart_delay_reg :
                         sel_st ? steering_reg :
                         sel_ss ? status_word : 8'h00;

    assign hrdata = {24'h000000, (req_reg.valid && !req_reg.write) ? rd_byte : 8'h00};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule : pos_top

/* test/pos_assertions.sv */
// Port checker for the PWM output steering block
`timescale 1ns/1ps
module pos_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0] channel_mode_field,
    input wire logic [1:0] output_config_field,
    input wire logic shutdown_event,
    input wire logic [3:0] port_data,
    input wire logic [3:0] pin_direction_control,
    input wire logic [3:0] pwm_pin_o,
    input wire logic [3:0] pwm_pin_oe,
    input wire logic shutdown_status_flag,
    input wire logic steer_active
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_ph_reg;
    logic rst_en_reg;
    logic [7:0] ph_addr_reg;
    // Forced level per pin: A and C follow mode bit 1, B and D bit 0
    wire logic [3:0] inv4 = {channel_mode_field[0], channel_mode_field[1],
                             channel_mode_field[0], channel_mode_field[1]};
    wire logic take = hsel && hready && htrans[1];
    wire logic w1c = wr_ph_reg && ph_addr_reg == pos_pkg::POS_OFF_STATUS && hwdata[0];
    ////////////////////////////////////////
    // Snoop writes, since the restart bit is not visible at the ports
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_reg <= 1'b0;
            rst_en_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else begin
            wr_ph_reg <= take && hwrite;
            if (take) begin
                ph_addr_reg <= haddr[7:0];
            end
            if (wr_ph_reg && ph_addr_reg == pos_pkg::POS_OFF_RESTART_DELAY) begin
                rst_en_reg <= hwdata[pos_pkg::POS_RD_RESTART_BIT];
            end
        end
    end
    sequence s_read_taken;
        take && !hwrite;
    endsequence
    sequence s_clear_due;
        shutdown_status_flag && !shutdown_event && rst_en_reg;
    endsequence
    ////////////////////////////////////////
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("Bus answer not ready or not OKAY");
    a_mode_decode: assert property (
        steer_active == (channel_mode_field[3:2] == 2'h3 && output_config_field == 2'h0))
        else $error("Steering decode wrong");
    a_port_pass: assert property ($past(hresetn) && !$past(steer_active) |-> pwm_pin_o == $past(port_data))
        else $error("Pins not under port control");
    a_oe_dir: assert property ($past(hresetn) |-> pwm_pin_oe == ~$past(pin_direction_control))
        else $error("Output enable does not follow direction");
    a_shut_set: assert property (shutdown_event |=> shutdown_status_flag)
        else $error("Shutdown flag not set");
    a_shut_force: assert property ($past(shutdown_status_flag) && $past(steer_active)
        |-> ((pwm_pin_o ^ $past(inv4)) & (pwm_pin_o ^ $past(port_data))) == 4'h0)
        else $error("Shutdown forced a wrong level");
    a_auto_clear: assert property (s_clear_due |=> !shutdown_status_flag)
        else $error("Flag not cleared by auto restart");
    a_flag_sticky: assert property (shutdown_status_flag && !rst_en_reg && !w1c |=> shutdown_status_flag)
        else $error("Flag cleared without software");
    a_rdata_upper: assert property (s_read_taken |=> hrdata[31:8] == 24'h0)
        else $error("Upper read data not zero");
    a_rsvd_zero: assert property (s_read_taken ##0 haddr[7:0] == pos_pkg::POS_OFF_STEERING
        |=> hrdata[7:5] == 3'h0)
        else $error("Unused steering bits read nonzero");
endmodule : pos_assertions

bind pos_top pos_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .channel_mode_field(channel_mode_field), .output_config_field(output_config_field),
    .shutdown_event(shutdown_event), .port_data(port_data), .pin_direction_control(pin_direction_control),
    .pwm_pin_o(pwm_pin_o), .pwm_pin_oe(pwm_pin_oe), .shutdown_status_flag(shutdown_status_flag),
    .steer_active(steer_active));

/* test/pos_pin_load.sv */
// Model of the loads on the four steered pins
`timescale 1ns/1ps
module pos_pin_load (
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_level
);
    // Weak pull-downs: a pin whose driver is off reads low, never the last driven value
    assign pin_level = pin_o & pin_oe;
endmodule : pos_pin_load

/* test/tb_top.sv */
// Self-checking bench for the PWM output steering block
`timescale 1ns/1ps
module tb_top;
    localparam int DLY = 3;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] mode = 4'hc;
    logic [1:0] cfg = 2'h0;
    logic pstart = 1'b0, raw = 1'b0, shut = 1'b0, tog = 1'b0, seen = 1'b0, rd_ph = 1'b0;
    logic [3:0] pdata = 4'h0, dir = 4'h0;
    logic hreadyout, hresp, flag, act;
    logic [31:0] hrdata;
    logic [3:0] pin_o, pin_oe, lvl;
    logic [7:0] rd_q[$];
    logic [3:0] pin_q[$];
    int error_cnt = 0, n_compared = 0;
    // Free-running 250 MHz clock
    always #2 hclk = ~hclk;
    pos_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .channel_mode_field(mode), .output_config_field(cfg), .period_start(pstart), .pwm_raw(raw),
        .shutdown_event(shut), .port_data(pdata), .pin_direction_control(dir), .pwm_pin_o(pin_o),
        .pwm_pin_oe(pin_oe), .shutdown_status_flag(flag), .steer_active(act));
    pos_pin_load u_load (.pin_o(pin_o), .pin_oe(pin_oe), .pin_level(lvl));
    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Oldest note is taken whenever a read data phase ends or a pin sample falls due
    always @(posedge hclk) begin
        if (rd_ph) begin
            cmp(hrdata, {24'h0, rd_q.pop_front()});
        end
        if (tog != seen) begin
            cmp({28'h0, lvl}, {28'h0, pin_q.pop_front()});
            seen = tog;
        end
        rd_ph <= hsel && hreadyout && htrans[1] && !hwrite;
    end
    ////////////////////////////////////////
    // Bounded wait for hready; a hang counts as a mismatch
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
            if (n > 20) begin
                error_cnt++;
                tally_and_finish;
            end
        end while (hreadyout !== 1'b1);
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask : rd
    // Pin value after the current edge is compared one edge later
    task automatic chk_pin(input logic [3:0] exp);
        pin_q.push_back(exp & ~dir);
        tog <= ~tog;
        @(posedge hclk);
    endtask : chk_pin
    function automatic logic [3:0] pexp(input logic [3:0] en, input logic r, input logic s);
        logic [3:0] inv;
        logic [3:0] val;
        inv = {mode[0], mode[1], mode[0], mode[1]};
        val = s ? inv : ({4{r}} ^ inv);
        if (mode[3:2] != 2'h3 || cfg != 2'h0) begin
            return pdata;
        end
        return (en & val) | (~en & pdata);
    endfunction : pexp
    ////////////////////////////////////////
    initial begin
        void'($urandom(15174));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        dir <= 4'($urandom) & 4'ha;
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h01);
        rd(8'h08, 8'h12);
        rd(8'h0c, 8'h00);
        bus(1'b1, 8'h04, 8'hfa);
        rd(8'h04, 8'h1a);
        rd(8'h08, 8'h12);
        pstart <= 1'b1;
        @(posedge hclk);
        pstart <= 1'b0;
        rd(8'h08, 8'ha2);
        bus(1'b1, 8'h04, 8'h05);
        rd(8'h08, 8'h52);
        // Every polarity with both raw levels, random port data on unsteered pins
        for (int i = 0; i < 8; i++) begin
            mode <= {2'h3, 2'(i)};
            raw <= i[2];
            pdata <= 4'($urandom);
            repeat (3) @(posedge hclk);
            chk_pin(pexp(4'h5, i[2], 1'b0));
        end
        cfg <= 2'h1;
        repeat (2) @(posedge hclk);
        chk_pin(pdata);
        rd(8'h08, 8'h50);
        cfg <= 2'h0;
        mode <= 4'hc;
        raw <= 1'b0;
        bus(1'b1, 8'h00, 8'(DLY));
        rd(8'h00, 8'(DLY));
        bus(1'b1, 8'h04, 8'h0f);
        repeat (4) @(posedge hclk);
        chk_pin(pexp(4'hf, 1'b0, 1'b0));
        raw <= 1'b1;
        repeat (4 * DLY + 1) @(posedge hclk);
        chk_pin(pexp(4'hf, 1'b0, 1'b0));
        chk_pin(pexp(4'hf, 1'b1, 1'b0));
        bus(1'b1, 8'h04, 8'h05);
        shut <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_pin(pexp(4'h5, 1'b1, 1'b1));
        shut <= 1'b0;
        repeat (3) @(posedge hclk);
        rd(8'h08, 8'h53);
        chk_pin(pexp(4'h5, 1'b1, 1'b1));
        bus(1'b1, 8'h08, 8'h01);
        repeat (3) @(posedge hclk);
        chk_pin(pexp(4'h5, 1'b1, 1'b0));
        bus(1'b1, 8'h00, 8'h80);
        rd(8'h00, 8'h80);
        shut <= 1'b1;
        repeat (2) @(posedge hclk);
        shut <= 1'b0;
        repeat (3) @(posedge hclk);
        rd(8'h08, 8'h52);
        chk_pin(pexp(4'h5, 1'b1, 1'b0));
        repeat (2) @(posedge hclk);
        tally_and_finish;
    end
endmodule : tb_top
